// ==== hdl/stp_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef STP_MAP_SVH
`define STP_MAP_SVH
// ==========================================
// Register offsets
`define STP_CTRL_OFS      8'h00
`define STP_VOLT_OFS      8'h04
`define STP_CURR_OFS      8'h08
`define STP_SECOND_OUTPUT_VOLTAGE_SETTING_OFS     8'h0c
`define STP_SECOND_OUTPUT_CURRENT_SETTING_OFS     8'h10
`define STP_TRIG_VOLT_OFS 8'h14
`define STP_TRIG_CURR_OFS 8'h18
`define STP_OVP_LVL_OFS   8'h1c
`define STP_PROT_DLY_OFS  8'h20
`define STP_CMD_OFS       8'h24
`define STP_STATUS_OFS    8'h28
`define STP_INTERVAL_OFS  8'h2c
`define STP_POINTS_OFS    8'h30
`define STP_RESULT_OFS    8'h34
`define STP_SRE_OFS       8'h38
`define STP_ESE_OFS       8'h3c
// ==========================================
// Control fields
`define STP_CTRL_OUT_EN   0
`define STP_CTRL_OVP_EN   1
`define STP_CTRL_OCP_EN   2
`define STP_CTRL_CONT     3
`define STP_CTRL_HANN     4
// ==========================================
// Command fields
`define STP_CMD_ABORT     0
`define STP_CMD_RESET     1
`define STP_CMD_RECALL    2
`define STP_CMD_INIT      3
`define STP_CMD_TRIG      4
`define STP_CMD_SRC_BUS   5
`define STP_CMD_CLS       6
`define STP_CMD_MEAS      7
`define STP_CMD_FUNC_LO   8
// ==========================================
// Reset values
`define STP_CTRL_RST      5'h12
`define STP_LEVEL_RST     16'h0000
`define STP_MASK_RST      8'h00
`define STP_PROT_DLY_RST  16'h0000
// ==========================================
// Timing
`define STP_CLK_MHZ         25
`define STP_SAMPLE_PERIOD_NS 15600
`define STP_SAMPLE_CYCLES   ((`STP_SAMPLE_PERIOD_NS * `STP_CLK_MHZ) / 1000)
`define STP_SAMPLE_COUNT    2048
`define STP_ACQ_TIME_MS     32
`endif

// ==== hdl/stp_pkg.sv ====
// Types of the source trigger and protection controller
package stp_pkg;
  typedef enum logic [2:0] {
    STP_T_IDLE   = 3'b001,
    STP_T_INIT   = 3'b010,
    STP_T_CHANGE = 3'b100
  } stp_trig_t;
  typedef enum logic [3:0] {
    STP_M_IDLE = 4'b0001,
    STP_M_FILL = 4'b0010,
    STP_M_CALC = 4'b0100,
    STP_M_DONE = 4'b1000
  } stp_meas_t;
  typedef enum logic [1:0] {
    STP_F_VOLT = 2'h0,
    STP_F_CURR = 2'h1,
    STP_F_DVM  = 2'h2
  } stp_func_t;
endpackage : stp_pkg

// ==== hdl/stp_mem_if.sv ====
// Sample buffer port bundle
`timescale 1ns/10ps
interface stp_mem_if #(parameter int DW = 16, parameter int AW = 11);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : stp_mem_if

// ==== hdl/stp_sample_mem.sv ====
// Measurement sample buffer with registered read
`timescale 1ns/10ps
module stp_sample_mem #(
  parameter int DW = 16,
  parameter int AW = 11
) (
  input wire logic clk,
  stp_mem_if.mem   mp
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (mp.wr_en) begin
      mem_q[mp.wr_addr] <= mp.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    mp.rd_data <= mem_q[mp.rd_addr];
  end
endmodule : stp_sample_mem

// ==== hdl/stp_ctrl.sv ====
// Output, protection, transient trigger and measurement control
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "stp_map.svh"
module stp_ctrl import stp_pkg::*; #(
  parameter int DW      = 16,
  parameter int AW      = 11,
  parameter int SAMPLES = `STP_SAMPLE_COUNT
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [15:0] volt_sense,
  input  wire logic [15:0] curr_sense,
  input  wire logic [15:0] dvm_sense,
  output logic             out_enable,
  output logic             out2_enable,
  output logic      [15:0] volt_drive,
  output logic      [15:0] curr_limit,
  output logic      [15:0] second_output_voltage_setting_level,
  output logic      [15:0] second_output_current_setting_level,
  output logic             op_complete
);
  localparam logic [AW:0]  CNT_DEF = (AW+1)'(SAMPLES);
  localparam logic [15:0]  INT_DEF = 16'(`STP_SAMPLE_CYCLES);

  // ==========================================
  // Helpers
  function automatic logic wr_hit(input logic [7:0] ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction : wr_hit

  function automatic logic [23:0] window_weight(input logic hann, input logic [AW:0] idx,
                                                input logic [AW:0] n);
    logic [AW:0] rest;
    rest = n - idx - (AW+1)'(1);
    if (!hann) return 24'h000001;
    return 24'(idx) * 24'(rest) + 24'h000001;
  endfunction : window_weight

  // ==========================================
  // Register state
  logic [4:0]  ctrl_q;
  logic [15:0] volt_set_q, curr_set_q, second_output_voltage_setting_q, second_output_current_setting_q;
  logic [15:0] trig_volt_q, trig_curr_q;
  logic        trig_volt_wr_q, trig_curr_wr_q;
  logic [15:0] overvoltage_trip_level_q, protection_trip_delay_q;
  logic [7:0]  sre_q, ese_q;
  logic [15:0] interval_q;
  logic [AW:0] points_q;
  logic [15:0] result_q;
  logic        ovp_flag_q, ocp_flag_q, meas_done_q;
  logic [31:0] reg_rdata_q;
  stp_trig_t   trig_q;
  stp_meas_t   meas_q;
  stp_func_t   func_q;

  logic cmd_wr, soft_rst, to_idle, fire, ovp_trip, ocp_trip, at_limit, prog_change;
  logic [15:0] dly_q, drive_q;
  logic        out_en_q;

  always_comb begin
    cmd_wr      = wr_hit(`STP_CMD_OFS);
    prog_change = wr_hit(`STP_VOLT_OFS) || wr_hit(`STP_CURR_OFS) ||
                  (trig_q == STP_T_CHANGE) || wr_hit(`STP_CTRL_OFS);
  end
  assign soft_rst = cmd_wr && reg_wdata[`STP_CMD_RESET];
  assign to_idle  = cmd_wr && (reg_wdata[`STP_CMD_ABORT] || reg_wdata[`STP_CMD_RESET] ||
                               reg_wdata[`STP_CMD_RECALL]);
  assign fire     = cmd_wr && reg_wdata[`STP_CMD_TRIG];

  // ==========================================
  // Settings
  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      ctrl_q                   <= `STP_CTRL_RST;
      volt_set_q               <= `STP_LEVEL_RST;
      curr_set_q               <= `STP_LEVEL_RST;
      second_output_voltage_setting_q                  <= `STP_LEVEL_RST;
      second_output_current_setting_q                  <= `STP_LEVEL_RST;
      trig_volt_q              <= `STP_LEVEL_RST;
      trig_curr_q              <= `STP_LEVEL_RST;
      trig_volt_wr_q           <= 1'b0;
      trig_curr_wr_q           <= 1'b0;
      overvoltage_trip_level_q <= `STP_LEVEL_RST;
      protection_trip_delay_q  <= `STP_PROT_DLY_RST;
      interval_q               <= INT_DEF;
      points_q                 <= CNT_DEF;
    end else begin
      if (wr_hit(`STP_CTRL_OFS)) ctrl_q <= reg_wdata[4:0];
      if (wr_hit(`STP_SECOND_OUTPUT_VOLTAGE_SETTING_OFS)) second_output_voltage_setting_q <= reg_wdata[15:0];
      if (wr_hit(`STP_SECOND_OUTPUT_CURRENT_SETTING_OFS)) second_output_current_setting_q <= reg_wdata[15:0];
      if (wr_hit(`STP_OVP_LVL_OFS)) overvoltage_trip_level_q <= reg_wdata[15:0];
      if (wr_hit(`STP_PROT_DLY_OFS)) protection_trip_delay_q <= reg_wdata[15:0];
      if (wr_hit(`STP_INTERVAL_OFS) && reg_wdata[15:0] != 16'h0000) begin
        interval_q <= reg_wdata[15:0];
      end
      if (wr_hit(`STP_POINTS_OFS) && reg_wdata != 32'h0 && reg_wdata <= 32'(CNT_DEF)) begin
        points_q <= reg_wdata[AW:0];
      end
      if (wr_hit(`STP_VOLT_OFS)) begin
        volt_set_q <= reg_wdata[15:0];
        if (!trig_volt_wr_q) trig_volt_q <= reg_wdata[15:0];
      end
      if (wr_hit(`STP_CURR_OFS)) begin
        curr_set_q <= reg_wdata[15:0];
        if (!trig_curr_wr_q) trig_curr_q <= reg_wdata[15:0];
      end
      if (wr_hit(`STP_TRIG_VOLT_OFS)) begin
        trig_volt_q    <= reg_wdata[15:0];
        trig_volt_wr_q <= 1'b1;
      end
      if (wr_hit(`STP_TRIG_CURR_OFS)) begin
        trig_curr_q    <= reg_wdata[15:0];
        trig_curr_wr_q <= 1'b1;
      end
      if (trig_q == STP_T_CHANGE) begin
        volt_set_q     <= trig_volt_q;
        curr_set_q     <= trig_curr_q;
        trig_volt_wr_q <= 1'b0;
        trig_curr_wr_q <= 1'b0;
      end
    end
  end

  // Event and service masks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sre_q <= `STP_MASK_RST;
      ese_q <= `STP_MASK_RST;
    end else begin
      if (wr_hit(`STP_SRE_OFS)) sre_q <= reg_wdata[7:0];
      if (wr_hit(`STP_ESE_OFS)) ese_q <= reg_wdata[7:0];
    end
  end

  // ==========================================
  // Transient trigger system (sequence one)
  always_ff @(posedge clk) begin
    if (!rst_n || to_idle) begin
      trig_q <= STP_T_IDLE;
    end else begin
      case (trig_q)
        STP_T_IDLE: begin
          if ((cmd_wr && reg_wdata[`STP_CMD_INIT]) || ctrl_q[`STP_CTRL_CONT]) begin
            trig_q <= STP_T_INIT;
          end
        end
        STP_T_INIT: begin
          if (fire) trig_q <= STP_T_CHANGE;
        end
        STP_T_CHANGE: begin
          trig_q <= ctrl_q[`STP_CTRL_CONT] ? STP_T_INIT : STP_T_IDLE;
        end
        default: trig_q <= STP_T_IDLE;
      endcase
    end
  end

  // ==========================================
  // Output enable and protection
  assign at_limit    = curr_sense >= curr_set_q;
  assign ovp_trip    = out_en_q && ctrl_q[`STP_CTRL_OVP_EN] &&
                       (volt_sense > overvoltage_trip_level_q);
  assign ocp_trip    = out_en_q && ctrl_q[`STP_CTRL_OCP_EN] && at_limit &&
                       (dly_q == 16'h0000);

  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst || prog_change || !at_limit) begin
      dly_q <= (!rst_n || soft_rst) ? `STP_PROT_DLY_RST : protection_trip_delay_q;
    end else if (dly_q != 16'h0000) begin
      dly_q <= dly_q - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      out_en_q <= 1'b0;
    end else if (ovp_trip || ocp_trip) begin
      out_en_q <= 1'b0;
    end else if (wr_hit(`STP_CTRL_OFS)) begin
      out_en_q <= reg_wdata[`STP_CTRL_OUT_EN];
    end
  end

  // Constant-current fold-back of the drive voltage
  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst || !out_en_q) begin
      drive_q <= 16'h0000;
    end else if (curr_sense > curr_set_q) begin
      if (drive_q != 16'h0000) drive_q <= drive_q - 16'h0001;
    end else if (drive_q < volt_set_q) begin
      drive_q <= drive_q + 16'h0001;
    end else begin
      drive_q <= volt_set_q;
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovp_flag_q <= 1'b0;
      ocp_flag_q <= 1'b0;
    end else begin
      ovp_flag_q <= ovp_trip || (ovp_flag_q && !(cmd_wr && reg_wdata[`STP_CMD_CLS]));
      ocp_flag_q <= ocp_trip || (ocp_flag_q && !(cmd_wr && reg_wdata[`STP_CMD_CLS]));
    end
  end

  // ==========================================
  // Measurement system (sequence two)
  stp_mem_if #(.DW(DW), .AW(AW)) mif ();

  stp_sample_mem #(.DW(DW), .AW(AW)) u_buf (
    .clk (clk),
    .mp  (mif.mem)
  );

  logic [15:0] tick_q;
  logic [AW:0] idx_q, acc_idx_q;
  logic        rd_vld_q;
  logic [63:0] acc_q, wsum_q;
  logic [15:0] sample;
  logic        meas_go;

  assign meas_go = cmd_wr && reg_wdata[`STP_CMD_MEAS];
  assign sample  = (func_q == STP_F_CURR) ? curr_sense :
                   (func_q == STP_F_DVM)  ? dvm_sense  : volt_sense;

  assign mif.wr_en   = (meas_q == STP_M_FILL) && (tick_q == 16'h0000);
  assign mif.wr_addr = idx_q[AW-1:0];
  assign mif.wr_data = sample[DW-1:0];
  assign mif.rd_addr = idx_q[AW-1:0];

  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      meas_q    <= STP_M_IDLE;
      func_q    <= STP_F_VOLT;
      tick_q    <= 16'h0000;
      idx_q     <= '0;
      acc_idx_q <= '0;
      rd_vld_q  <= 1'b0;
      acc_q     <= 64'h0;
      wsum_q    <= 64'h0;
      result_q  <= 16'h0000;
    end else begin
      case (meas_q)
        STP_M_IDLE: begin
          if (meas_go) begin
            func_q <= stp_func_t'(reg_wdata[`STP_CMD_FUNC_LO+1:`STP_CMD_FUNC_LO]);
            meas_q <= STP_M_FILL;
            tick_q <= 16'h0000;
            idx_q  <= '0;
          end
        end
        STP_M_FILL: begin
          if (tick_q != 16'h0000) begin
            tick_q <= tick_q - 16'h0001;
          end else begin
            tick_q <= interval_q - 16'h0001;
            if (idx_q == points_q - (AW+1)'(1)) begin
              meas_q <= STP_M_CALC;
              idx_q  <= '0;
              acc_q  <= 64'h0;
              wsum_q <= 64'h0;
            end else begin
              idx_q <= idx_q + (AW+1)'(1);
            end
          end
        end
        STP_M_CALC: begin
          rd_vld_q  <= idx_q < points_q;
          acc_idx_q <= idx_q;
          if (idx_q < points_q) idx_q <= idx_q + (AW+1)'(1);
          if (rd_vld_q) begin
            acc_q  <= acc_q + 64'(window_weight(ctrl_q[`STP_CTRL_HANN], acc_idx_q, points_q))
                            * 64'(mif.rd_data);
            wsum_q <= wsum_q + 64'(window_weight(ctrl_q[`STP_CTRL_HANN], acc_idx_q, points_q));
          end else if (idx_q == points_q) begin
            meas_q <= STP_M_DONE;
          end
        end
        STP_M_DONE: begin
          result_q <= (wsum_q == 64'h0) ? 16'h0000 : 16'(acc_q / wsum_q);
          meas_q   <= STP_M_IDLE;
        end
        default: meas_q <= STP_M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meas_done_q <= 1'b0;
    end else begin
      meas_done_q <= (meas_q == STP_M_DONE) ||
                     (meas_done_q && !(cmd_wr && reg_wdata[`STP_CMD_CLS]) && !meas_go);
    end
  end

  // ==========================================
  // Register read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `STP_CTRL_OFS:      reg_rdata_q <= {27'h0, ctrl_q[4:1], out_en_q};
        `STP_VOLT_OFS:      reg_rdata_q <= {16'h0, volt_set_q};
        `STP_CURR_OFS:      reg_rdata_q <= {16'h0, curr_set_q};
        `STP_SECOND_OUTPUT_VOLTAGE_SETTING_OFS:     reg_rdata_q <= {16'h0, second_output_voltage_setting_q};
        `STP_SECOND_OUTPUT_CURRENT_SETTING_OFS:     reg_rdata_q <= {16'h0, second_output_current_setting_q};
        `STP_TRIG_VOLT_OFS: reg_rdata_q <= {16'h0, trig_volt_q};
        `STP_TRIG_CURR_OFS: reg_rdata_q <= {16'h0, trig_curr_q};
        `STP_OVP_LVL_OFS:   reg_rdata_q <= {16'h0, overvoltage_trip_level_q};
        `STP_PROT_DLY_OFS:  reg_rdata_q <= {16'h0, protection_trip_delay_q};
        `STP_STATUS_OFS:    reg_rdata_q <= {19'h0, func_q, meas_q, meas_done_q,
                                            ocp_flag_q, ovp_flag_q, op_complete, trig_q};
        `STP_INTERVAL_OFS:  reg_rdata_q <= {16'h0, interval_q};
        `STP_POINTS_OFS:    reg_rdata_q <= 32'(points_q);
        `STP_RESULT_OFS:    reg_rdata_q <= {16'h0, result_q};
        `STP_SRE_OFS:       reg_rdata_q <= {24'h0, sre_q};
        `STP_ESE_OFS:       reg_rdata_q <= {24'h0, ese_q};
        default:            reg_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  // ==========================================
  // Outputs
  assign reg_rdata   = reg_rdata_q;
  assign out_enable  = out_en_q;
  assign out2_enable = out_en_q;
  assign volt_drive  = drive_q;
  assign curr_limit  = curr_set_q;
  assign second_output_voltage_setting_level = second_output_voltage_setting_q;
  assign second_output_current_setting_level = second_output_current_setting_q;
  assign op_complete = (trig_q == STP_T_IDLE) && (meas_q == STP_M_IDLE);
endmodule : stp_ctrl

// ==== verification/stp_load_model.sv ====
// Load and sense model behind the output terminals
`timescale 1ns/10ps
module stp_load_model (
  input  wire logic        out_enable,
  input  wire logic [15:0] volt_drive,
  input  wire logic [15:0] load_curr,
  output logic      [15:0] volt_sense,
  output logic      [15:0] curr_sense
);
  // ==========================================
  // Terminals go dead when the output is off
  assign volt_sense = out_enable ? volt_drive : 16'h0000;
  assign curr_sense = out_enable ? load_curr : 16'h0000;
endmodule : stp_load_model

// ==== verification/stp_ctrl_chk.sv ====
// Port checker of the controller
`timescale 1ns/10ps
module stp_ctrl_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] volt_sense,
  input wire logic [15:0] curr_sense,
  input wire logic        out_enable,
  input wire logic        out2_enable,
  input wire logic [15:0] volt_drive,
  input wire logic [15:0] curr_limit,
  input wire logic        op_complete
);
  // ==========================================
  // Shadow protection settings
  logic        ovp_en_q;
  logic        ocp_en_q;
  logic [15:0] lvl_q;
  logic [15:0] dly_q;
  logic        soft_rst;
  assign soft_rst = reg_wr && reg_addr == 8'h24 && reg_wdata[1];
  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      ovp_en_q <= 1'b1;
      ocp_en_q <= 1'b0;
      lvl_q    <= 16'h0000;
      dly_q    <= 16'h0000;
    end else if (reg_wr) begin
      if (reg_addr == 8'h00) begin
        ovp_en_q <= reg_wdata[1];
        ocp_en_q <= reg_wdata[2];
      end
      if (reg_addr == 8'h1c) lvl_q <= reg_wdata[15:0];
      if (reg_addr == 8'h20) dly_q <= reg_wdata[15:0];
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_reset_state: assert property (
    $rose(rst_n) |-> !out_enable && volt_drive == 16'h0000 && op_complete)
    else $error("output not off after reset");
  chk_outputs_paired: assert property (out2_enable == out_enable)
    else $error("second output differs from main");
  chk_ovp_trip: assert property (
    out_enable && ovp_en_q && volt_sense > lvl_q && !reg_wr |=> !out_enable)
    else $error("overvoltage did not switch off");
  chk_no_trip: assert property (
    out_enable && !ocp_en_q && !reg_wr && !(ovp_en_q && volt_sense > lvl_q)
    |=> out_enable) else $error("output dropped without cause");
  chk_ocp_trip: assert property (
    ocp_en_q && dly_q == 16'h0000 && out_enable && curr_sense >= curr_limit
    && !reg_wr ##1 !reg_wr [*2] |=> !out_enable) else $error("overcurrent kept on");
  chk_limit_lowers: assert property (
    out_enable && curr_sense > curr_limit && volt_drive != 16'h0000 && !reg_wr
    |=> volt_drive < $past(volt_drive)) else $error("drive not lowered at limit");
  chk_drive_off: assert property (
    !out_enable ##1 !out_enable |-> volt_drive == 16'h0000)
    else $error("drive present with output off");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule : stp_ctrl_chk
bind stp_ctrl stp_ctrl_chk i_stp_ctrl_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .volt_sense(volt_sense), .curr_sense(curr_sense), .out_enable(out_enable),
  .out2_enable(out2_enable), .volt_drive(volt_drive), .curr_limit(curr_limit),
  .op_complete(op_complete));

// ==== verification/tb_top.sv ====
// Self-checking bench of the controller
`timescale 1ns/10ps
module tb_top;
  logic        clk, rst_n, reg_wr, reg_rd, out_enable, out2_enable, op_complete;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, s, v1, v2, v3;
  logic [15:0] volt_sense, curr_sense, dvm_sense, volt_drive, curr_limit, load_curr;
  logic [15:0] second_output_voltage_setting_level, second_output_current_setting_level;
  int          bad_count, samples_checked, cycles, i;
  integer      seed;
  stp_ctrl i_stp_ctrl (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .volt_sense(volt_sense),
    .curr_sense(curr_sense), .dvm_sense(dvm_sense), .out_enable(out_enable),
    .out2_enable(out2_enable), .volt_drive(volt_drive), .curr_limit(curr_limit),
    .second_output_voltage_setting_level(second_output_voltage_setting_level), .second_output_current_setting_level(second_output_current_setting_level), .op_complete(op_complete));
  stp_load_model i_stp_load_model (.out_enable(out_enable), .volt_drive(volt_drive),
    .load_curr(load_curr), .volt_sense(volt_sense), .curr_sense(curr_sense));
  // ==========================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ==========================================
  // Bus and compare tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    s = reg_rdata;
  endtask : rd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_out(input logic lv, input int n);
    for (i = 0; i < n && out_enable !== lv; i++) @(negedge clk);
  endtask : wait_out
  // Trigger state and completion flag in status low bits
  function automatic logic [31:0] st_exp(input logic [2:0] t);
    return {28'h0, t == 3'b001, t};
  endfunction : st_exp
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // ==========================================
  // Main sequence
  initial begin
    seed = 32'h09c79cfc;
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    dvm_sense = 16'h0000; load_curr = 16'h0000;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00); chk("ctrl", 32'h12, s);
    rd(8'h04); chk("voltage", 32'h0, s);
    rd(8'h38); chk("sre", 32'h0, s);
    rd(8'h3c); chk("ese", 32'h0, s);
    rd(8'h2c); chk("interval", 32'h186, s);
    rd(8'h30); chk("points", 32'h800, s);
    wr(8'h30, 32'h1800); rd(8'h30); chk("points refused", 32'h800, s);
    rd(8'h40); chk("unmapped", 32'h0, s);
    rd(8'h28); chk("status", st_exp(3'b001), {28'h0, s[3:0]});
    wr(8'h0c, 32'h1234); wr(8'h10, 32'h5678); @(negedge clk);
    chk("second_output_voltage_setting", 32'h1234, {16'h0, second_output_voltage_setting_level});
    chk("second_output_current_setting", 32'h5678, {16'h0, second_output_current_setting_level});
    $display("test reset done");
    v1 = $random(seed) & 32'hffff; v2 = $random(seed) & 32'hffff; v3 = $random(seed) & 32'hffff;
    wr(8'h04, v1); rd(8'h14); chk("trig level", v1, s);
    wr(8'h14, v2); wr(8'h04, v3); rd(8'h14); chk("trig held", v2, s);
    wr(8'h24, 32'h30); rd(8'h04); chk("idle trig", v3, s);
    wr(8'h24, 32'h08); rd(8'h28); chk("armed", st_exp(3'b010), {28'h0, s[3:0]});
    wr(8'h24, 32'h10); rd(8'h04); chk("applied", v2, s);
    rd(8'h28); chk("single", st_exp(3'b001), {28'h0, s[3:0]});
    wr(8'h04, v1); rd(8'h14); chk("tracks", v1, s);
    wr(8'h00, 32'h1a); rd(8'h28); chk("cont arm", st_exp(3'b010), {28'h0, s[3:0]});
    wr(8'h14, v3); wr(8'h24, 32'h10); rd(8'h04); chk("cont apply", v3, s);
    rd(8'h28); chk("cont rearm", st_exp(3'b010), {28'h0, s[3:0]});
    wr(8'h00, 32'h12); wr(8'h24, 32'h10);
    rd(8'h28); chk("cont off", st_exp(3'b001), {28'h0, s[3:0]});
    for (int k = 0; k < 3; k++) begin
      wr(8'h24, 32'h08); wr(8'h24, 32'h1 << k);
      rd(8'h28); chk("force idle", st_exp(3'b001), {28'h0, s[3:0]});
    end
    $display("test trigger done");
    wr(8'h1c, 32'h20); wr(8'h04, 32'h40); wr(8'h00, 32'h13);
    @(negedge clk); chk("both on", 32'h1, {31'h0, out2_enable});
    wait_out(1'b0, 100); chk("ovp trip", 32'h0, {31'h0, out_enable});
    rd(8'h28); chk("ovp flag", 32'h1, {31'h0, s[4]});
    wr(8'h00, 32'h11); repeat (100) @(negedge clk);
    chk("ovp off", 32'h1, {31'h0, out_enable});
    chk("ramp", 32'h40, {16'h0, volt_drive});
    @(posedge clk);
    load_curr <= 16'h0200 | 16'($random(seed) & 32'h0000_00ff);
    wr(8'h08, 32'h100); repeat (20) @(negedge clk);
    chk("limited", 32'h1, {31'h0, volt_drive < 16'h0040});
    chk("ocp off", 32'h1, {31'h0, out_enable});
    wr(8'h20, 32'd20); wr(8'h00, 32'h15); repeat (10) @(negedge clk);
    chk("delayed", 32'h1, {31'h0, out_enable});
    wait_out(1'b0, 40); chk("ocp trip", 32'h0, {31'h0, out_enable});
    wr(8'h20, 32'h0); wr(8'h00, 32'h15);
    wait_out(1'b0, 5); chk("ocp fast", 32'h0, {31'h0, out_enable});
    @(posedge clk);
    load_curr <= 16'h0000;
    $display("test protection done");
    dvm_sense <= 16'($random(seed));
    wr(8'h2c, 32'h2); wr(8'h30, 32'h8); wr(8'h24, 32'h08);
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, k == 1 ? 32'h12 : 32'h02); wr(8'h24, k == 2 ? 32'h1c0 : 32'h2c0);
      s = 32'h0;
      for (i = 0; i < 100 && s[6] !== 1'b1; i++) rd(8'h28);
      chk("meas done", 32'h1, {31'h0, s[6]});
      rd(8'h34); chk("result", k == 2 ? 32'h0 : {16'h0, dvm_sense}, s);
    end
    rd(8'h28); chk("trig apart", st_exp(3'b010), {28'h0, s[3:0]});
    $display("test measurement done");
    end_of_test();
  end
endmodule : tb_top
